// File: core/erm_ram.sv
// Purpose: two-port embedded RAM in input/output clock mode
// Assumes: port clocks and controls are pins, sampled through two flip-flops
// Notes: read data registers are never cleared, they read unknown until first read
`timescale 1ns/1ps
module erm_ram
	import erm_pkg::*;
#(
	parameter erm_mode_t MODE    = ERM_TDP,
	parameter int        WIDTH_A = 18,
	parameter int        WIDTH_B = 18
)(
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire erm_pin_t             pin_a,
	input  wire erm_pin_t             pin_b,
	output logic [ERM_MAX_W-1:0]      dout_a,
	output logic [ERM_MAX_W-1:0]      dout_b
);

	localparam int  DEPTH_A = erm_depth(WIDTH_A);
	localparam int  DEPTH_B = erm_depth(WIDTH_B);
	localparam int  LANE_A  = erm_lane(WIDTH_A);
	localparam int  LANE_B  = erm_lane(WIDTH_B);
	// wide ports cannot share the array two ways, port B drops to read-only
	localparam bit  B_WR_OK = (MODE == ERM_TDP) && (WIDTH_A <= ERM_TDP_MAX_W)
		&& (WIDTH_B <= ERM_TDP_MAX_W);
	localparam bit  A_RD_OK = (MODE != ERM_SDP);
	localparam bit  B_RD_OK = (MODE != ERM_SP);

	logic [ERM_TOTAL_BITS-1:0] mem_reg;
	erm_cap_t                  cap_a;
	erm_cap_t                  cap_b;
	logic                      wr_go_a;
	logic                      wr_go_b;
	logic                      rd_go_a;
	logic                      rd_go_b;
	logic                      wr_a;
	logic                      wr_b;
	logic                      in_rng_a;
	logic                      in_rng_b;
	logic [ERM_MAX_W-1:0]      rd_a;
	logic [ERM_MAX_W-1:0]      rd_b;
	logic [ERM_MAX_W-1:0]      dout_a_reg;
	logic [ERM_MAX_W-1:0]      dout_b_reg;

	erm_port_front u_front_a (
		.mclk  (mclk),
		.rstn  (rstn),
		.pins  (pin_a),
		.cap   (cap_a),
		.wr_go (wr_go_a),
		.rd_go (rd_go_a)
	);

	erm_port_front u_front_b (
		.mclk  (mclk),
		.rstn  (rstn),
		.pins  (pin_b),
		.cap   (cap_b),
		.wr_go (wr_go_b),
		.rd_go (rd_go_b)
	);

	assign in_rng_a = int'(cap_a.addr) < DEPTH_A;
	assign in_rng_b = int'(cap_b.addr) < DEPTH_B;
	assign wr_a     = wr_go_a & in_rng_a;
	assign wr_b     = wr_go_b & in_rng_b & B_WR_OK & (MODE != ERM_SP);

	// port A is applied after port B at each bit index, so at equal widths it wins a same-bit collision
	always_ff @(posedge mclk) begin
		for (int j = 0; j < ERM_MAX_W; j++) begin
			if (j < WIDTH_B && wr_b && cap_b.be[j / LANE_B])
				mem_reg[erm_phys(int'(cap_b.addr) * WIDTH_B + j, WIDTH_B)] <= cap_b.din[j];
			if (j < WIDTH_A && wr_a && cap_a.be[j / LANE_A])
				mem_reg[erm_phys(int'(cap_a.addr) * WIDTH_A + j, WIDTH_A)] <= cap_a.din[j];
		end
	end

	always_comb begin
		rd_a = '0;
		rd_b = '0;
		for (int j = 0; j < ERM_MAX_W; j++) begin
			if (j < WIDTH_A && in_rng_a)
				rd_a[j] = mem_reg[erm_phys(int'(cap_a.addr) * WIDTH_A + j, WIDTH_A)];
			if (j < WIDTH_B && in_rng_b)
				rd_b[j] = mem_reg[erm_phys(int'(cap_b.addr) * WIDTH_B + j, WIDTH_B)];
		end
	end

	// output registers: no reset at all, only the output clock moves them
	always_ff @(posedge mclk) begin
		if (rd_go_a && A_RD_OK)
			dout_a_reg <= rd_a;
	end

	always_ff @(posedge mclk) begin
		if (rd_go_b && B_RD_OK)
			dout_b_reg <= rd_b;
	end

	assign dout_a = dout_a_reg;
	assign dout_b = dout_b_reg;

	chk_out_only_edge: assert property (@(posedge mclk) disable iff (!rstn)
		!rd_go_a |=> $stable(dout_a))
		else $error("port A read data moved without an enabled output edge");

	chk_out_b_edge: assert property (@(posedge mclk) disable iff (!rstn)
		!(rd_go_b && B_RD_OK) |=> $stable(dout_b))
		else $error("port B read data moved without an enabled output edge");

	chk_read_value: assert property (@(posedge mclk) disable iff (!rstn)
		(rd_go_a && A_RD_OK) |=> dout_a == $past(rd_a))
		else $error("port A output did not load the addressed word");

	chk_no_clear: assert property (@(posedge mclk)
		(!rstn && !rd_go_a) |=> $stable(dout_a))
		else $error("port A output register cleared by reset");

	chk_write_lands: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_a && !wr_b && (&cap_a.be)) |=> rd_a == ($past(cap_a.din)
			& ((ERM_MAX_W'(1) << WIDTH_A) - ERM_MAX_W'(1))))
		else $error("port A write did not land in the array");

	chk_lane_mask: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_a && !wr_b && !cap_a.be[0]) |=> rd_a[0] == $past(rd_a[0]))
		else $error("masked byte lane was written");

	chk_b_write_gate: assert property (@(posedge mclk) disable iff (!rstn)
		wr_go_b && !B_WR_OK && !wr_a |=> $stable(mem_reg))
		else $error("port B wrote outside true dual-port narrow widths");

	chk_range_drop: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_go_a && !in_rng_a && !wr_b) |=> $stable(mem_reg))
		else $error("write beyond array depth changed storage");

	chk_dual_write: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_b && !wr_a && (&cap_b.be) && B_WR_OK) |=> rd_b == ($past(cap_b.din)
			& ((ERM_MAX_W'(1) << WIDTH_B) - ERM_MAX_W'(1))))
		else $error("port B write did not land in the array");

endmodule

// File: core/erm_pkg.sv
// Purpose: shared constants and carriers for the two-port embedded RAM block
// Assumes: port clocks arrive as pins and are sampled on mclk
// Notes: storage is a flat bit array; parity widths use the ninth bit of each byte
package erm_pkg;

	localparam int ERM_DATA_BITS  = 4096;
	localparam int ERM_PAR_BITS   = 512;
	localparam int ERM_TOTAL_BITS = ERM_DATA_BITS + ERM_PAR_BITS;
	localparam int ERM_MAX_W      = 36;
	localparam int ERM_MAX_BE     = 4;
	localparam int ERM_ADDR_W     = 12;
	localparam int ERM_TDP_MAX_W  = 18;
	localparam int ERM_LANE_PLAIN = 8;
	localparam int ERM_LANE_PAR   = 9;

	typedef enum logic [1:0] {ERM_TDP, ERM_SDP, ERM_SP} erm_mode_t;

	typedef struct packed {
		logic                  clk_in;
		logic                  clk_out;
		logic                  in_ce;
		logic                  out_ce;
		logic                  we;
		logic [ERM_ADDR_W-1:0] addr;
		logic [ERM_MAX_W-1:0]  din;
		logic [ERM_MAX_BE-1:0] be;
	} erm_pin_t;

	typedef struct packed {
		logic                  we;
		logic [ERM_ADDR_W-1:0] addr;
		logic [ERM_MAX_W-1:0]  din;
		logic [ERM_MAX_BE-1:0] be;
	} erm_cap_t;

	function automatic bit erm_is_par(input int w);
		return (w % ERM_LANE_PAR) == 0;
	endfunction

	function automatic int erm_depth(input int w);
		return (erm_is_par(w) ? ERM_TOTAL_BITS : ERM_DATA_BITS) / w;
	endfunction

	function automatic int erm_lane(input int w);
		return erm_is_par(w) ? ERM_LANE_PAR : ERM_LANE_PLAIN;
	endfunction

	// plain widths skip the parity bit of every 9-bit byte
	function automatic int erm_phys(input int bit_idx, input int w);
		if (erm_is_par(w))
			return bit_idx;
		return (bit_idx / ERM_LANE_PLAIN) * ERM_LANE_PAR + (bit_idx % ERM_LANE_PLAIN);
	endfunction

endpackage

// File: core/erm_port_front.sv
// Purpose: one RAM port front end: pin sampling, clock edge detect, input register
// Assumes: port clock pins high and low for at least two mclk periods each
// Notes: captured fields carry no reset, only the write strobe does
`timescale 1ns/1ps
module erm_port_front
	import erm_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     rstn,
	input  wire erm_pin_t pins,
	output erm_cap_t      cap,
	output logic          wr_go,
	output logic          rd_go
);

	erm_pin_t s1_reg;
	erm_pin_t s2_reg;
	logic     ci_prev_reg;
	logic     co_prev_reg;
	erm_cap_t cap_reg;
	logic     wr_go_reg;
	logic     in_edge;
	logic     out_edge;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_reg      <= '0;
			s2_reg      <= '0;
			ci_prev_reg <= 1'b0;
			co_prev_reg <= 1'b0;
		end else begin
			s1_reg      <= pins;
			s2_reg      <= s1_reg;
			ci_prev_reg <= s2_reg.clk_in;
			co_prev_reg <= s2_reg.clk_out;
		end
	end

	assign in_edge  = s2_reg.clk_in & ~ci_prev_reg;
	assign out_edge = s2_reg.clk_out & ~co_prev_reg;
	assign rd_go    = out_edge & s2_reg.out_ce;

	// no clear on the input register; it only moves on an enabled edge
	always_ff @(posedge mclk) begin
		if (in_edge && s2_reg.in_ce) begin
			cap_reg.we   <= s2_reg.we;
			cap_reg.addr <= s2_reg.addr;
			cap_reg.din  <= s2_reg.din;
			cap_reg.be   <= s2_reg.be;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_go_reg <= 1'b0;
		end else begin
			wr_go_reg <= in_edge & s2_reg.in_ce & s2_reg.we;
		end
	end

	assign cap   = cap_reg;
	assign wr_go = wr_go_reg;

	chk_in_capture: assert property (@(posedge mclk) disable iff (!rstn)
		(in_edge && s2_reg.in_ce) |=> (cap.addr == $past(s2_reg.addr)) && wr_go == $past(s2_reg.we))
		else $error("input register missed an enabled input clock edge");

	chk_in_hold: assert property (@(posedge mclk) disable iff (!rstn)
		!(in_edge && s2_reg.in_ce) |=> $stable(cap) && !wr_go)
		else $error("input register changed without an enabled edge");

endmodule

// File: dv/erm_user.sv
// Purpose: fabric user logic driving the pins of one RAM port
// Assumes: pins change 1 ns after a rising mclk edge
// Notes: din is inverted once its hold has run out, so stale data never looks valid
`timescale 1ns/1ps
module erm_user
	import erm_pkg::*;
(
	input  wire logic mclk,
	output erm_pin_t  pins
);
	initial pins = '0;

	// one input capture, then one output update of the same port
	task automatic op(input logic w, input logic [11:0] a, input logic [35:0] d,
		input logic [3:0] be, input logic ice, input logic oce);
		@(posedge mclk) #1;
		pins = '{clk_in:1'h0, clk_out:1'h0, in_ce:ice, out_ce:oce, we:w, addr:a, din:d, be:be};
		@(posedge mclk) #1;
		pins.clk_in = 1'h1;
		repeat (3) @(posedge mclk);
		#1;
		pins.clk_in = 1'h0;
		repeat (2) @(posedge mclk);
		#1;
		pins.din = ~pins.din;
		pins.clk_out = 1'h1;
		repeat (3) @(posedge mclk);
		#1;
		pins.clk_out = 1'h0;
		repeat (3) @(posedge mclk);
	endtask
endmodule

// File: dv/erm_ram_tb.sv
// Purpose: self-checking bench for the two-port RAM in true, simple and single-port setups
// Assumes: port pins are driven by five user-logic models
// Notes: dout has no reset, so each check reads a value loaded by an earlier enabled output edge, or X where a port never loads one
`timescale 1ns/1ps
module erm_ram_tb
	import erm_pkg::*;
;
	logic        mclk;
	logic        rstn;
	erm_pin_t    pin_a;
	erm_pin_t    pin_b;
	logic [35:0] dout_a;
	logic [35:0] dout_b;
	erm_pin_t    pin_c;
	erm_pin_t    pin_d;
	erm_pin_t    pin_e;
	logic [35:0] dout_c;
	logic [35:0] dout_d;
	logic [35:0] dout_e;
	logic [35:0] dout_f;
	int          n_errors;
	int          checked;
	int          cycles;

	erm_ram #(.MODE(ERM_TDP), .WIDTH_A(18), .WIDTH_B(18)) DUT (.mclk(mclk), .rstn(rstn),
		.pin_a(pin_a), .pin_b(pin_b), .dout_a(dout_a), .dout_b(dout_b));
	erm_user ua (.mclk(mclk), .pins(pin_a));
	erm_user ub (.mclk(mclk), .pins(pin_b));

	// plain widths: a 32-bit writer and a byte reader over one array
	erm_ram #(.MODE(ERM_SDP), .WIDTH_A(32), .WIDTH_B(8)) DUT_SDP (.mclk(mclk), .rstn(rstn),
		.pin_a(pin_c), .pin_b(pin_d), .dout_a(dout_c), .dout_b(dout_d));
	// port B shares the byte reader's pins; single-port mode must ignore them
	erm_ram #(.MODE(ERM_SP), .WIDTH_A(9), .WIDTH_B(9)) DUT_SP (.mclk(mclk), .rstn(rstn),
		.pin_a(pin_e), .pin_b(pin_d), .dout_a(dout_e), .dout_b(dout_f));
	erm_user uc (.mclk(mclk), .pins(pin_c));
	erm_user ud (.mclk(mclk), .pins(pin_d));
	erm_user ue (.mclk(mclk), .pins(pin_e));

	initial mclk = 1'h0;
	always #20 mclk = ~mclk;

	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic t_basic();
		ua.op(1'h1, 12'h005, 36'h00002A5A5, 4'hF, 1'h1, 1'h1);
		chk("a readback", 36'h00002A5A5, dout_a);
		ub.op(1'h0, 12'h005, 36'h000000000, 4'h0, 1'h1, 1'h1);
		chk("b read of a word", 36'h00002A5A5, dout_b);
		$display("test basic done");
	endtask

	task automatic t_reset();
		@(posedge mclk) #1;
		rstn = 1'h0;
		repeat (2) @(posedge mclk);
		#1;
		rstn = 1'h1;
		chk("dout across reset", 36'h00002A5A5, dout_a);
		ua.op(1'h0, 12'h005, 36'h000000000, 4'h0, 1'h1, 1'h1);
		chk("word across reset", 36'h00002A5A5, dout_a);
		$display("test reset done");
	endtask

	task automatic t_lanes();
		ua.op(1'h1, 12'h006, 36'h00003FFFF, 4'hF, 1'h1, 1'h1);
		ua.op(1'h1, 12'h006, 36'h000000000, 4'h1, 1'h1, 1'h1);
		chk("lane 0 only", 36'h00003FE00, dout_a);
		ua.op(1'h1, 12'h006, 36'h000000000, 4'h0, 1'h1, 1'h1);
		chk("no lane", 36'h00003FE00, dout_a);
		$display("test lanes done");
	endtask

	task automatic t_enables();
		ua.op(1'h1, 12'h014, 36'h000012345, 4'hF, 1'h1, 1'h1);
		ua.op(1'h1, 12'h014, 36'h00000BEEF, 4'hF, 1'h0, 1'h1);
		chk("input enable low", 36'h000012345, dout_a);
		ua.op(1'h0, 12'h006, 36'h000000000, 4'h0, 1'h1, 1'h0);
		chk("output enable low", 36'h000012345, dout_a);
		$display("test enables done");
	endtask

	task automatic t_dual();
		fork
			ua.op(1'h1, 12'h020, 36'h000011111, 4'hF, 1'h1, 1'h1);
			ub.op(1'h1, 12'h021, 36'h000022222, 4'hF, 1'h1, 1'h1);
		join
		chk("two writes a", 36'h000011111, dout_a);
		chk("two writes b", 36'h000022222, dout_b);
		fork
			ua.op(1'h0, 12'h021, 36'h000000000, 4'h0, 1'h1, 1'h1);
			ub.op(1'h0, 12'h020, 36'h000000000, 4'h0, 1'h1, 1'h1);
		join
		chk("two reads a", 36'h000022222, dout_a);
		chk("two reads b", 36'h000011111, dout_b);
		$display("test dual done");
	endtask

	task automatic t_range();
		ua.op(1'h1, 12'h0FF, 36'h00003C3C3, 4'hF, 1'h1, 1'h1);
		chk("last word", 36'h00003C3C3, dout_a);
		ua.op(1'h1, 12'h100, 36'h000015555, 4'hF, 1'h1, 1'h1);
		chk("past depth", 36'h000000000, dout_a);
		$display("test range done");
	endtask

	// byte k of 32-bit word 3 is byte address 12+k on the narrow side
	task automatic t_sdp();
		uc.op(1'h1, 12'h003, 36'h089ABCDEF, 4'hF, 1'h1, 1'h1);
		chk("sdp a output held", 36'hXXXXXXXXX, dout_c);
		ud.op(1'h0, 12'h00C, 36'h000000000, 4'h0, 1'h1, 1'h1);
		chk("sdp byte 0", 36'h0000000EF, dout_d);
		ud.op(1'h0, 12'h00F, 36'h000000000, 4'h0, 1'h1, 1'h1);
		chk("sdp byte 3", 36'h000000089, dout_d);
		uc.op(1'h1, 12'h003, 36'h000000000, 4'h2, 1'h1, 1'h1);
		ud.op(1'h0, 12'h00D, 36'h000000000, 4'h0, 1'h1, 1'h1);
		chk("sdp lane 1", 36'h000000000, dout_d);
		ud.op(1'h1, 12'h00C, 36'h000000055, 4'hF, 1'h1, 1'h1);
		chk("sdp b write refused", 36'h0000000EF, dout_d);
		$display("test simple dual done");
	endtask

	task automatic t_sp();
		ue.op(1'h1, 12'h1FF, 36'h0000001A5, 4'h1, 1'h1, 1'h1);
		chk("sp last word", 36'h0000001A5, dout_e);
		ue.op(1'h1, 12'h1FF, 36'h0000000FF, 4'h0, 1'h1, 1'h1);
		chk("sp masked lane", 36'h0000001A5, dout_e);
		chk("sp b ignored", 36'hXXXXXXXXX, dout_f);
		$display("test single port done");
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		rstn = 1'h0;
		repeat (4) @(posedge mclk);
		#1;
		rstn = 1'h1;
		t_basic();
		t_reset();
		t_lanes();
		t_enables();
		t_dual();
		t_range();
		t_sdp();
		t_sp();
		wrap_up();
	end
endmodule
